//--- src/cio_image.sv
// cyclic input image builder with parameter channel for fieldbus I/O scanning
`timescale 1ns/100ps
module cio_image #(
   parameter int MAP_MAX = 3
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic clk_en,
   input wire logic cyc_write,
   input wire cio_pkg::cio_param_ctrl_t param_req_control,
   input wire logic [31:0] param_req_value,
   input wire logic cyc_read,
   input wire logic [1:0] map_count,
   input wire cio_pkg::cio_status_t status,
   output cio_pkg::cio_pacc_req_t acc_req,
   input wire cio_pkg::cio_pacc_rsp_t acc_rsp,
   output logic [cio_pkg::IMAGE_W-1:0] input_image,
   output logic [4:0] image_length,
   output logic image_valid
);
   import cio_pkg::*;

   cio_param_ctrl_t param_resp_control;
   logic [31:0] param_resp_value;
   logic [IMAGE_W-1:0] next_image;
   logic [4:0] next_length;
   logic [1:0] eff_maps;
   logic snapshot;

   // place a field of nbytes at byte offset ofs, most significant byte first
   function automatic logic [IMAGE_W-1:0] place(input logic [IMAGE_W-1:0] img, input int ofs,
                                                input int nbytes, input logic [31:0] val);
      logic [IMAGE_W-1:0] r;
      r = img;
      for (int k = 0; k < 4; k++) begin
         if (k < nbytes) begin
            r[8*(ofs+k)+:8] = val[8*(nbytes-1-k)+:8];
         end
      end
      return r;
   endfunction : place

   // motion status word; reserved bits stay zero
   function automatic logic [15:0] motion_word(input cio_motion_t m);
      logic [15:0] w;
      w = 16'h0000;
      w[MB_LIM_POS] = m.positive_limit_input;
      w[MB_LIM_NEG] = m.negative_limit_input;
      w[MB_STILL] = m.motor_standstill;
      w[MB_MOV_POS] = m.motor_moving_positive;
      w[MB_MOV_NEG] = m.motor_moving_negative;
      w[MB_INT_A] = m.internal_limit_a;
      w[MB_INT_B] = m.internal_limit_b;
      w[MB_PROF_STILL] = m.profile_standstill;
      w[MB_PROF_DEC] = m.profile_decelerating;
      w[MB_PROF_ACC] = m.profile_accelerating;
      w[MB_PROF_PROFILE_STEADY_SPEED] = m.profile_steady_speed;
      return w;
   endfunction : motion_word

   // digital input word; bits 6, 7 and 12 to 15 read zero
   function automatic logic [15:0] din_word(input logic [5:0] base, input logic [3:0] expansion);
      logic [15:0] w;
      w = 16'h0000;
      w[DIN_BASE_POS+:6] = base;
      w[DIN_EXP_POS+:4] = expansion;
      return w;
   endfunction : din_word

   // handshake engine
   cio_param_chan u_chan (
      .clk(clk),
      .reset(reset),
      .clk_en(clk_en),
      .req_strobe(cyc_write),
      .param_req_control(param_req_control),
      .param_req_value(param_req_value),
      .acc_req(acc_req),
      .acc_rsp(acc_rsp),
      .param_resp_control(param_resp_control),
      .param_resp_value(param_resp_value)
   );

   // mapped slots beyond the configured count read as zero
   assign eff_maps = (int'(map_count) > MAP_MAX) ? MAP_MAX[1:0] : map_count;
   assign next_length = LEN_BASE + {2'b00, eff_maps, 1'b0};
   assign snapshot = cyc_read && (image_valid || cyc_write);

   // assemble the image from the live sources
   always_comb begin
      next_image = IMAGE_RESET;
      next_image = place(next_image, OFS_RESP_CTRL, 4, param_resp_control);
      next_image = place(next_image, OFS_RESP_VAL, 4, param_resp_value);
      next_image = place(next_image, OFS_STATE, 2, {16'h0000, status.operating_state_word});
      next_image = place(next_image, OFS_MODE, 2, {16'h0000, status.operating_mode_word});
      next_image = place(next_image, OFS_MOTION, 2, {16'h0000, motion_word(status.motion)});
      next_image = place(next_image, OFS_DIN, 2,
                         {16'h0000, din_word(status.base_inputs, status.expansion_io_module)});
      next_image = place(next_image, OFS_POS, 4, status.position);
      next_image = place(next_image, OFS_VEL, 4, status.velocity);
      next_image = place(next_image, OFS_CUR, 2, {16'h0000, status.current});
      if (eff_maps > 2'd0) begin
         next_image = place(next_image, OFS_MAP1, 4, status.mapped_input_value_1);
      end
      if (eff_maps > 2'd1) begin
         next_image = place(next_image, OFS_MAP1 + MAP_STRIDE, 4, status.mapped_input_value_2);
      end
      if (eff_maps > 2'd2) begin
         next_image = place(next_image, OFS_MAP1 + 2*MAP_STRIDE, 4, status.mapped_input_value_3);
      end
   end

   // first cyclic write enables the image
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         image_valid <= 1'b0;
      end else if (clk_en && cyc_write) begin
         image_valid <= 1'b1;
      end
   end

   // one consistent snapshot per exchange, zero before the first write
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         input_image <= IMAGE_RESET;
      end else if (clk_en && snapshot) begin
         input_image <= next_image;
      end
   end

   // data length for the scan, grows by two registers per mapped value
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         image_length <= LEN_RESET;
      end else if (clk_en && snapshot) begin
         image_length <= next_length;
      end
   end

   property p_zero_before_write;
      @(posedge clk) disable iff (reset)
      !image_valid |-> (input_image == IMAGE_RESET);
   endproperty
   a_zero_before_write: assert property (p_zero_before_write) else $error("image not zero before write");

   property p_state_snapshot;
      @(posedge clk) disable iff (reset)
      (clk_en && snapshot) |=> (input_image[8*OFS_STATE+:8] == $past(status.operating_state_word[15:8]))
      && (input_image[8*(OFS_STATE+1)+:8] == $past(status.operating_state_word[7:0]));
   endproperty
   a_state_snapshot: assert property (p_state_snapshot) else $error("state word not snapshotted");

   property p_hold_between;
      @(posedge clk) disable iff (reset)
      (!(clk_en && snapshot)) |=> $stable(input_image);
   endproperty
   a_hold_between: assert property (p_hold_between) else $error("image changed between exchanges");

   property p_limit_bits;
      @(posedge clk) disable iff (reset)
      (clk_en && snapshot) |=> (input_image[8*(OFS_MOTION+1)+MB_LIM_POS] == $past(status.motion.positive_limit_input))
      && (input_image[8*(OFS_MOTION+1)+MB_LIM_NEG] == $past(status.motion.negative_limit_input));
   endproperty
   a_limit_bits: assert property (p_limit_bits) else $error("limit switch bits wrong");

   property p_unmapped_zero;
      @(posedge clk) disable iff (reset)
      (clk_en && snapshot && eff_maps == 2'd0) |=> (input_image[IMAGE_W-1:8*OFS_MAP1] == '0)
      && (image_length == LEN_BASE);
   endproperty
   a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped slots not zero");

   c_first_snap: cover property (@(posedge clk) disable iff (reset) clk_en && snapshot && !image_valid);
   c_full_map: cover property (@(posedge clk) disable iff (reset) clk_en && snapshot && eff_maps == 2'd3);
endmodule : cio_image

//--- src/cio_pkg.sv
// shared constants and carrier types for the cyclic input image and parameter channel
package cio_pkg;
   // request codes sent by the master
   localparam logic [7:0] CODE_NONE = 8'h02;
   localparam logic [7:0] CODE_READ = 8'h12;
   localparam logic [7:0] CODE_WR_WORD = 8'h22;
   localparam logic [7:0] CODE_WR_DWORD = 8'h32;
   // response codes returned by the device
   localparam logic [7:0] RSP_PEND = 8'h02;
   localparam logic [7:0] RSP_WORD = 8'h12;
   localparam logic [7:0] RSP_DWORD = 8'h22;
   localparam logic [7:0] RSP_ERR = 8'h72;
   localparam logic [31:0] ERR_NO_PARAM = 32'h0000_1101;
   localparam logic [7:0] SUB_ZERO = 8'h00;
   localparam logic [31:0] RESP_RESET = 32'h0000_0000;
   // byte offsets inside the input image
   localparam int OFS_RESP_CTRL = 0;
   localparam int OFS_RESP_VAL = 4;
   localparam int OFS_STATE = 8;
   localparam int OFS_MODE = 10;
   localparam int OFS_MOTION = 12;
   localparam int OFS_DIN = 14;
   localparam int OFS_POS = 16;
   localparam int OFS_VEL = 20;
   localparam int OFS_CUR = 24;
   localparam int OFS_MAP1 = 26;
   localparam int MAP_STRIDE = 4;
   localparam int IMAGE_BYTES = 38;
   localparam int IMAGE_W = IMAGE_BYTES * 8;
   localparam logic [IMAGE_W-1:0] IMAGE_RESET = '0;
   // motion status bit positions
   localparam int MB_LIM_POS = 0;
   localparam int MB_LIM_NEG = 1;
   localparam int MB_STILL = 6;
   localparam int MB_MOV_POS = 7;
   localparam int MB_MOV_NEG = 8;
   localparam int MB_INT_A = 9;
   localparam int MB_INT_B = 10;
   localparam int MB_PROF_STILL = 11;
   localparam int MB_PROF_DEC = 12;
   localparam int MB_PROF_ACC = 13;
   localparam int MB_PROF_PROFILE_STEADY_SPEED = 14;
   // digital input word layout
   localparam int DIN_BASE_POS = 0;
   localparam int DIN_EXP_POS = 8;
   // scan data length in 16-bit registers
   localparam logic [4:0] LEN_BASE = 5'h0D;
   localparam logic [4:0] LEN_RESET = 5'h00;

   typedef enum logic [1:0] {
      CIO_ST_IDLE = 2'b00,
      CIO_ST_ACCESS = 2'b01,
      CIO_ST_REFRESH = 2'b10
   } cio_state_t;

   typedef struct packed {
      logic [7:0] code;
      logic [7:0] sub;
      logic [15:0] index;
   } cio_param_ctrl_t;

   typedef struct packed {
      logic start;
      logic write;
      logic dword;
      logic [15:0] index;
      logic [31:0] wdata;
   } cio_pacc_req_t;

   typedef struct packed {
      logic done;
      logic exists;
      logic ok;
      logic dword;
      logic [31:0] value;
      logic [15:0] errnum;
   } cio_pacc_rsp_t;

   typedef struct packed {
      logic positive_limit_input;
      logic negative_limit_input;
      logic motor_standstill;
      logic motor_moving_positive;
      logic motor_moving_negative;
      logic internal_limit_a;
      logic internal_limit_b;
      logic profile_standstill;
      logic profile_decelerating;
      logic profile_accelerating;
      logic profile_steady_speed;
   } cio_motion_t;

   typedef struct packed {
      logic [15:0] operating_state_word;
      logic [15:0] operating_mode_word;
      cio_motion_t motion;
      logic [5:0] base_inputs;
      logic [3:0] expansion_io_module;
      logic [31:0] position;
      logic [31:0] velocity;
      logic [15:0] current;
      logic [31:0] mapped_input_value_1;
      logic [31:0] mapped_input_value_2;
      logic [31:0] mapped_input_value_3;
   } cio_status_t;
endpackage : cio_pkg

//--- src/cio_param_chan.sv
// parameter channel handshake: request edge detection, access sequencing, response
`timescale 1ns/100ps
module cio_param_chan (
   input wire logic clk,
   input wire logic reset,
   input wire logic clk_en,
   input wire logic req_strobe,
   input wire cio_pkg::cio_param_ctrl_t param_req_control,
   input wire logic [31:0] param_req_value,
   output cio_pkg::cio_pacc_req_t acc_req,
   input wire cio_pkg::cio_pacc_rsp_t acc_rsp,
   output cio_pkg::cio_param_ctrl_t param_resp_control,
   output logic [31:0] param_resp_value
);
   import cio_pkg::*;

   cio_state_t state;
   logic [7:0] prev_code;
   logic resp_ok;
   logic busy;
   logic is_req;
   logic start_new;
   logic repeat_req;

   // a new request is accepted only on the step from no-request to a request code; repeating the last code after a good response starts a refresh read
   assign busy = (state != CIO_ST_IDLE);
   assign is_req = (param_req_control.code == CODE_READ) || (param_req_control.code == CODE_WR_WORD)
      || (param_req_control.code == CODE_WR_DWORD);
   assign start_new = req_strobe && !busy && (prev_code == CODE_NONE) && is_req;
   assign repeat_req = req_strobe && !busy && resp_ok && is_req && (prev_code == param_req_control.code);

   // last request code seen, for edge detection
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         prev_code <= CODE_NONE;
      end else if (clk_en && req_strobe) begin
         prev_code <= param_req_control.code;
      end
   end

   // one request at a time; a new request shows the pending code at once, the response value is held until it completes
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         state <= CIO_ST_IDLE;
         acc_req <= '0;
         resp_ok <= 1'b0;
         param_resp_control <= RESP_RESET;
         param_resp_value <= RESP_RESET;
      end else if (clk_en) begin
         acc_req.start <= 1'b0;
         case (state)
            CIO_ST_IDLE: begin
               if (start_new) begin
                  acc_req.start <= 1'b1;
                  acc_req.write <= (param_req_control.code != CODE_READ);
                  acc_req.dword <= (param_req_control.code == CODE_WR_DWORD);
                  acc_req.index <= param_req_control.index;
                  acc_req.wdata <= param_req_value;
                  param_resp_control <= {RSP_PEND, SUB_ZERO, param_req_control.index};
                  resp_ok <= 1'b0;
                  state <= CIO_ST_ACCESS;
               end else if (repeat_req) begin
                  acc_req.start <= 1'b1; // refresh with the current value
                  acc_req.write <= 1'b0;
                  state <= CIO_ST_REFRESH;
               end
            end
            CIO_ST_ACCESS, CIO_ST_REFRESH: begin
               if (acc_rsp.done) begin
                  state <= CIO_ST_IDLE;
                  if (!acc_rsp.exists) begin
                     param_resp_control.code <= RSP_ERR;
                     param_resp_value <= ERR_NO_PARAM;
                     resp_ok <= 1'b0;
                  end else if (!acc_rsp.ok) begin
                     param_resp_control.code <= RSP_ERR;
                     param_resp_value <= {16'h0000, acc_rsp.errnum};
                     resp_ok <= 1'b0;
                  end else begin
                     param_resp_control.code <= acc_rsp.dword ? RSP_DWORD : RSP_WORD;
                     param_resp_value <= acc_rsp.value;
                     resp_ok <= 1'b1;
                  end
               end
            end
            default: begin
               state <= CIO_ST_IDLE;
            end
         endcase
      end
   end

   property p_pend_on_start;
      @(posedge clk) disable iff (reset)
      (clk_en && start_new) |=> (param_resp_control.code == RSP_PEND) && acc_req.start;
   endproperty
   a_pend_on_start: assert property (p_pend_on_start) else $error("no pending code after start");

   property p_read_edge;
      @(posedge clk) disable iff (reset)
      (clk_en && !busy && req_strobe && prev_code == CODE_NONE && param_req_control.code == CODE_READ)
      |=> acc_req.start && !acc_req.write;
   endproperty
   a_read_edge: assert property (p_read_edge) else $error("read not started on code edge");

   property p_no_held_write;
      @(posedge clk) disable iff (reset)
      (clk_en && req_strobe && prev_code != CODE_NONE) |=> !(acc_req.start && acc_req.write);
   endproperty
   a_no_held_write: assert property (p_no_held_write) else $error("write started without edge");

   property p_no_param;
      @(posedge clk) disable iff (reset)
      (clk_en && busy && acc_rsp.done && !acc_rsp.exists)
      |=> (param_resp_control.code == RSP_ERR) && (param_resp_value == ERR_NO_PARAM);
   endproperty
   a_no_param: assert property (p_no_param) else $error("missing parameter error wrong");

   property p_err_value;
      @(posedge clk) disable iff (reset)
      (clk_en && busy && acc_rsp.done && acc_rsp.exists && !acc_rsp.ok)
      |=> (param_resp_control.code == RSP_ERR) && (param_resp_value == {16'h0000, $past(acc_rsp.errnum)});
   endproperty
   a_err_value: assert property (p_err_value) else $error("error number not returned");

   property p_success;
      @(posedge clk) disable iff (reset)
      (clk_en && busy && acc_rsp.done && acc_rsp.exists && acc_rsp.ok)
      |=> (param_resp_control.code == ($past(acc_rsp.dword) ? RSP_DWORD : RSP_WORD))
      && (param_resp_value == $past(acc_rsp.value));
   endproperty
   a_success: assert property (p_success) else $error("success response wrong");

   c_read: cover property (@(posedge clk) disable iff (reset) start_new && param_req_control.code == CODE_READ);
   c_write_dw: cover property (@(posedge clk) disable iff (reset) start_new && param_req_control.code == CODE_WR_DWORD);
   c_error: cover property (@(posedge clk) disable iff (reset) busy && acc_rsp.done && !acc_rsp.exists);
endmodule : cio_param_chan

//--- verif/cio_param_store.sv
// parameter store model that answers the access requests of the parameter channel
`timescale 1ns/100ps
module cio_param_store #(
   parameter logic [15:0] ERRN = 16'h0B0C // arbitrary refusal number
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic slow,
   input wire cio_pkg::cio_pacc_req_t acc_req,
   output cio_pkg::cio_pacc_rsp_t acc_rsp
);
   import cio_pkg::*;
   logic [15:0] idx [4];
   logic [31:0] mem [4];
   cio_pacc_req_t held;
   logic [4:0] cnt;
   int hit;
   assign idx = '{16'h0102, 16'h0200, 16'h0300, 16'h0400};
   // find the addressed entry, entry 2 is read-only and entry 3 a word
   always_comb begin
      hit = -1;
      for (int i = 0; i < 4; i++) if (idx[i] == held.index) hit = i;
   end
   // hold the request, wait the latency, then answer with one done pulse
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         cnt <= '0;
         held <= '0;
         acc_rsp <= '0;
         mem <= '{32'h0001_6440, 32'h0000_0000, 32'h0000_0077, 32'h0000_00AB};
      end else begin
         acc_rsp.done <= 1'b0;
         acc_rsp.value <= ~acc_rsp.value; // stale value keeps changing
         if (acc_req.start) begin
            held <= acc_req;
            cnt <= slow ? 5'h0C : 5'h01;
         end else if (cnt == 5'h01) begin
            cnt <= '0;
            acc_rsp.done <= 1'b1;
            acc_rsp.exists <= (hit >= 0);
            acc_rsp.ok <= (hit >= 0) && !(held.write && hit == 2);
            acc_rsp.dword <= held.write ? held.dword : (hit != 3);
            acc_rsp.errnum <= ERRN;
            if (hit < 0) begin
               acc_rsp.value <= 32'hFFFF_FFFF;
            end else if (held.write && hit != 2) begin
               mem[hit] <= held.dword ? held.wdata : {16'h0000, held.wdata[15:0]};
               acc_rsp.value <= held.dword ? held.wdata : {16'h0000, held.wdata[15:0]};
            end else begin
               acc_rsp.value <= mem[hit];
            end
         end else if (cnt != '0) begin
            cnt <= cnt - 5'h01;
         end
      end
   end
endmodule : cio_param_store

//--- verif/tb_top.sv
// self-checking bench for the cyclic input image and parameter channel
`timescale 1ns/100ps
module tb_top;
   import cio_pkg::*;
   localparam int SW = $bits(cio_status_t);
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic clk_en = 1'b1;
   logic cyc_write = 1'b0;
   logic cyc_read = 1'b0;
   logic slow = 1'b0;
   logic [1:0] map_count = 2'h0;
   cio_param_ctrl_t param_req_control = '0;
   logic [31:0] param_req_value = '0;
   cio_status_t status = '0;
   cio_pacc_req_t acc_req;
   cio_pacc_rsp_t acc_rsp;
   logic [IMAGE_W-1:0] input_image;
   logic [4:0] image_length;
   logic image_valid;
   logic [31:0] seed = 32'h0000_005C;
   logic [31:0] ev;
   logic [31:0] v;
   int done_cnt = 0;
   int bad_count = 0;
   int num_checks = 0;

   cio_image u_cio_image (.clk(clk), .reset(reset), .clk_en(clk_en), .cyc_write(cyc_write),
      .param_req_control(param_req_control), .param_req_value(param_req_value), .cyc_read(cyc_read),
      .map_count(map_count), .status(status), .acc_req(acc_req), .acc_rsp(acc_rsp),
      .input_image(input_image), .image_length(image_length), .image_valid(image_valid));
   cio_param_store u_cio_param_store (.clk(clk), .reset(reset), .slow(slow), .acc_req(acc_req),
      .acc_rsp(acc_rsp));

   // clock and count of finished accesses
   always #12.5 clk = ~clk;
   always @(posedge clk) if (acc_rsp.done === 1'b1) done_cnt <= done_cnt + 1;

   function automatic logic [31:0] rnd();
      seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
      return seed;
   endfunction : rnd

   // one big-endian field placed in an otherwise empty image
   function automatic logic [IMAGE_W-1:0] fld(int ofs, int nb, logic [31:0] x);
      logic [IMAGE_W-1:0] r;
      r = '0;
      for (int b = 0; b < nb; b++) r[(ofs + b) * 8 +: 8] = x[(nb - 1 - b) * 8 +: 8];
      return r;
   endfunction : fld

   // expected image from response, status and mapping count
   function automatic logic [IMAGE_W-1:0] exp_img(logic [31:0] c, logic [31:0] pv, cio_status_t s, int m);
      logic [15:0] mw;
      logic [15:0] dw;
      mw = '0;
      mw[0] = s.motion.positive_limit_input;
      mw[1] = s.motion.negative_limit_input;
      mw[8:6] = {s.motion.motor_moving_negative, s.motion.motor_moving_positive, s.motion.motor_standstill};
      mw[10:9] = {s.motion.internal_limit_b, s.motion.internal_limit_a};
      mw[14:11] = {s.motion.profile_steady_speed, s.motion.profile_accelerating,
         s.motion.profile_decelerating, s.motion.profile_standstill};
      dw = {4'h0, s.expansion_io_module, 2'h0, s.base_inputs};
      return fld(0, 4, c) | fld(4, 4, pv) | fld(8, 2, s.operating_state_word) | fld(10, 2, s.operating_mode_word)
         | fld(12, 2, mw) | fld(14, 2, dw) | fld(16, 4, s.position) | fld(20, 4, s.velocity)
         | fld(24, 2, s.current) | (m > 0 ? fld(26, 4, s.mapped_input_value_1) : '0)
         | (m > 1 ? fld(30, 4, s.mapped_input_value_2) : '0) | (m > 2 ? fld(34, 4, s.mapped_input_value_3) : '0);
   endfunction : exp_img

   task automatic chk(logic [IMAGE_W-1:0] got, logic [IMAGE_W-1:0] exp);
      num_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] %0t image mismatch got %h exp %h", $time, got[63:0], exp[63:0]);
      end
   endtask : chk

   // compare a narrow status output
   task automatic chk_s(logic [4:0] got, logic [4:0] exp);
      num_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] %0t status mismatch got %h exp %h", $time, got, exp);
      end
   endtask : chk_s

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : give_verdict

   // one output image exchange carrying the parameter request
   task automatic send(logic [7:0] code, logic [15:0] idx, logic [31:0] val);
      @(posedge clk);
      cyc_write <= 1'b1;
      param_req_control <= '{code: code, sub: SUB_ZERO, index: idx};
      param_req_value <= val;
      @(posedge clk);
      cyc_write <= 1'b0;
   endtask : send

   // snapshot the input image and compare bytes 0-7 and the rest
   task automatic snap(logic [31:0] c, logic [31:0] pv);
      @(posedge clk);
      cyc_read <= 1'b1;
      @(posedge clk);
      cyc_read <= 1'b0;
      repeat (3) @(posedge clk);
      chk(input_image, exp_img(c, pv, status, map_count));
      chk_s(image_length, 5'(13 + 2 * map_count));
   endtask : snap

   // complete a request; pre sends the idle code first
   task automatic req(bit pre, logic [7:0] code, logic [15:0] idx, logic [31:0] val);
      int d0;
      if (pre) send(CODE_NONE, idx, rnd());
      d0 = done_cnt;
      send(code, idx, val);
      for (int k = 0; k < 40 && done_cnt == d0; k++) @(posedge clk);
      if (pre && done_cnt == d0) begin
         bad_count++;
         $display("[FAIL] %0t access never finished", $time);
      end
      repeat (3) @(posedge clk);
   endtask : req

   initial begin
      repeat (16) @(posedge clk);
      reset <= 1'b0;
      status <= SW'({rnd(), rnd(), rnd(), rnd(), rnd(), rnd(), rnd(), rnd()});
      // a read exchange before any write leaves the image and length at zero
      @(posedge clk);
      cyc_read <= 1'b1;
      @(posedge clk);
      cyc_read <= 1'b0;
      repeat (3) @(posedge clk);
      chk(input_image, IMAGE_RESET);
      chk_s(image_length, LEN_RESET);
      chk_s({4'h0, image_valid}, 5'h00);
      send(CODE_NONE, 16'h0000, '0);
      for (int m = 0; m < 4; m++) begin
         @(posedge clk);
         status <= SW'({rnd(), rnd(), rnd(), rnd(), rnd(), rnd(), rnd(), rnd()});
         map_count <= 2'(m);
         snap('0, '0);
      end
      chk_s({4'h0, image_valid}, 5'h01);
      req(1, CODE_READ, 16'h0102, rnd());
      snap(32'h2200_0102, 32'h0001_6440);
      req(0, CODE_READ, 16'h0102, rnd());
      snap(32'h2200_0102, 32'h0001_6440);
      req(1, CODE_READ, 16'h0400, '0);
      snap(32'h1200_0400, 32'h0000_00AB);
      v = rnd();
      req(1, CODE_WR_DWORD, 16'h0200, v);
      snap(32'h2200_0200, v);
      req(0, CODE_WR_WORD, 16'h0200, ~v);
      snap(32'h2200_0200, v);
      req(1, CODE_READ, 16'h0200, '0);
      snap(32'h2200_0200, v);
      ev = rnd();
      req(1, CODE_WR_WORD, 16'h0400, ev);
      snap(32'h1200_0400, {16'h0000, ev[15:0]});
      req(1, CODE_WR_DWORD, 16'h0065, 32'h0000_00DE);
      snap(32'h7200_0065, ERR_NO_PARAM);
      req(1, CODE_WR_DWORD, 16'h0300, v);
      snap(32'h7200_0300, 32'h0000_0B0C);
      slow <= 1'b1;
      send(CODE_NONE, 16'h0102, '0);
      send(CODE_READ, 16'h0102, '0);
      snap(32'h0200_0102, 32'h0000_0B0C);
      repeat (12) @(posedge clk);
      snap(32'h2200_0102, 32'h0001_6440);
      // an exchange while the clock enable is low must leave the image frozen
      clk_en <= 1'b0;
      cyc_read <= 1'b1;
      status <= ~status;
      @(posedge clk);
      clk_en <= 1'b1;
      cyc_read <= 1'b0;
      @(posedge clk);
      chk(input_image, exp_img(32'h2200_0102, 32'h0001_6440, ~status, map_count));
      give_verdict();
   end

   // cut a hang short
   initial begin
      #(25 * 20000);
      bad_count++;
      give_verdict();
   end
endmodule : tb_top
